/* File: inc/spc_pkg.sv */
// constants shared by the axis register block and its rate generator
// assumes one axis per instance and a single 10 MHz reference clock
package spc_pkg;

    ////////////////////////////////////////////////////////////////
    // widths
    localparam int FEED_W = 24;
    localparam int STEP_W = 13;
    localparam int RAMP_W = 16;
    localparam int DIV_W = 10;
    localparam int SEL_W = 4;
    localparam int BUF_W = 24;

    ////////////////////////////////////////////////////////////////
    // register select codes
    localparam logic [3:0] SEL_FEED = 4'h0;
    localparam logic [3:0] SEL_START = 4'h1;
    localparam logic [3:0] SEL_MAX = 4'h2;
    localparam logic [3:0] SEL_RAMP = 4'h3;
    localparam logic [3:0] SEL_DIV = 4'h4;

    ////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [23:0] FEED_RST = 24'h000000;
    localparam logic [12:0] START_RST = 13'h0001;
    localparam logic [12:0] MAX_RST = 13'h0001;
    localparam logic [15:0] RAMP_RST = 16'h0001;
    localparam logic [9:0] DIV_RST = 10'h002;
    localparam logic [9:0] DIV_MIN = 10'h002;

    // the step accumulator wraps at 8192, giving step * fref / (div * 8192)
    localparam int ACC_W = 13;

    // s-curve ramps take twice the linear time per speed step
    localparam int S_CURVE_FACTOR_SHIFT = 1;

    typedef enum logic [1:0] {
        SPC_IDLE,
        SPC_RUN,
        SPC_DECEL
    } spc_state_t;

endpackage

/* File: rtl/spc_rate_gen.sv */
// rate generator: turns a speed step and a scale divisor into step pulses
// assumes speed_step and scale_divisor are steady between ramp updates
`timescale 1ns/1ns
module spc_rate_gen #(
    parameter int STEP_W = spc_pkg::STEP_W,
    parameter int DIV_W = spc_pkg::DIV_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [STEP_W-1:0] speed_step,
    input wire logic [DIV_W-1:0] scale_divisor,
    output logic step_pulse
);

    logic [DIV_W-1:0] presc;
    logic [spc_pkg::ACC_W:0] acc;
    logic [DIV_W-1:0] div_eff;
    logic tick;
    logic [spc_pkg::ACC_W:0] next_acc;

    ////////////////////////////////////////////////////////////////
    // divisor below the legal minimum is clamped, avoiding a stuck prescaler
    assign div_eff = (scale_divisor < spc_pkg::DIV_MIN) ? spc_pkg::DIV_MIN : scale_divisor;
    assign tick = run && (presc == div_eff - DIV_W'(1));
    assign next_acc = {1'b0, acc[spc_pkg::ACC_W-1:0]} + {1'b0, speed_step};

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            presc <= '0;
            acc <= '0;
            step_pulse <= 1'b0;
        end else begin
            presc <= (!run || tick) ? '0 : presc + DIV_W'(1);
            acc <= !run ? '0 : (tick ? next_acc : {1'b0, acc[spc_pkg::ACC_W-1:0]});
            step_pulse <= run && tick && next_acc[spc_pkg::ACC_W];
        end
    end

    ////////////////////////////////////////////////////////////////
    a_no_pulse_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !run |=> !step_pulse)
        else $error("step pulse while the generator is stopped");

endmodule

/* File: rtl/spc_axis.sv */
// one axis: feed-amount down counter, speed/ramp/scale registers, run control
// assumes host commands are one-cycle strobes on sys_clk; ext_stop_pin is async
`timescale 1ns/1ns
module spc_axis #(
    parameter int FEED_W = spc_pkg::FEED_W,
    parameter int STEP_W = spc_pkg::STEP_W,
    parameter int RAMP_W = spc_pkg::RAMP_W,
    parameter int DIV_W = spc_pkg::DIV_W
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [spc_pkg::SEL_W-1:0] register_select_code,
    input wire logic reg_write,
    input wire logic [spc_pkg::BUF_W-1:0] write_buffer,
    output logic [spc_pkg::BUF_W-1:0] read_buffer,
    input wire logic start_cmd,
    input wire logic stop_cmd,
    input wire logic decel_stop_cmd,
    input wire logic ext_stop_pin,
    input wire logic positioning_mode,
    input wire logic high_speed_mode,
    input wire logic s_curve_mode,
    input wire logic count_hold_bit,
    input wire logic int_on_stop_en,
    output logic busy_output_pin,
    output logic main_status_busy,
    output logic int_out,
    output logic step_pulse,
    output logic [STEP_W-1:0] current_speed
);

    logic [FEED_W-1:0] feed_amount_counter;
    logic [STEP_W-1:0] start_speed_step;
    logic [STEP_W-1:0] max_speed_step;
    logic [RAMP_W-1:0] ramp_rate;
    logic [DIV_W-1:0] speed_scale_divisor;
    spc_pkg::spc_state_t state;
    spc_pkg::spc_state_t next_state;
    logic [RAMP_W:0] ramp_cnt;
    logic ext_stop_meta;
    logic ext_stop_sync;
    logic ext_stop_prev;

    ////////////////////////////////////////////////////////////////
    // external stop: two flops, then edge detect on the second
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_stop_meta <= 1'b0;
            ext_stop_sync <= 1'b0;
            ext_stop_prev <= 1'b0;
        end else begin
            ext_stop_meta <= ext_stop_pin;
            ext_stop_sync <= ext_stop_meta;
            ext_stop_prev <= ext_stop_sync;
        end
    end

    ////////////////////////////////////////////////////////////////
    // register select decode
    wire running = (state != spc_pkg::SPC_IDLE);
    wire wr_feed = reg_write && (register_select_code == spc_pkg::SEL_FEED);
    wire wr_start = reg_write && (register_select_code == spc_pkg::SEL_START);
    wire wr_max = reg_write && (register_select_code == spc_pkg::SEL_MAX);
    wire wr_ramp = reg_write && (register_select_code == spc_pkg::SEL_RAMP);
    wire wr_div = reg_write && (register_select_code == spc_pkg::SEL_DIV);
    wire ext_stop_edge = ext_stop_sync && !ext_stop_prev;
    wire hard_stop = stop_cmd || ext_stop_edge;
    wire feed_zero = (feed_amount_counter == '0);
    wire zero_start = start_cmd && !running && positioning_mode && feed_zero;
    wire go = start_cmd && !running && !zero_start;
    wire count_en = step_pulse && !count_hold_bit;
    // last pulse of a positioning run
    wire pos_done = running && positioning_mode && count_en
        && (feed_amount_counter == FEED_W'(1));
    // one speed step per ramp_rate periods, twice that many in s-curve mode
    wire [RAMP_W:0] ramp_limit = s_curve_mode
        ? ({1'b0, ramp_rate} << spc_pkg::S_CURVE_FACTOR_SHIFT)
        : {1'b0, ramp_rate};
    wire ramp_tick = (ramp_cnt >= ramp_limit - (RAMP_W + 1)'(1));
    wire at_start_speed = (current_speed <= start_speed_step);
    // stop as soon as start speed is reached, no extra ramp period at the floor
    wire decel_end = (state == spc_pkg::SPC_DECEL) && at_start_speed;
    wire stopping = hard_stop || pos_done || decel_end;

    ////////////////////////////////////////////////////////////////
    // read mux: narrow registers padded with zero above their width
    wire [spc_pkg::BUF_W-1:0] rd_feed = feed_amount_counter;
    wire [spc_pkg::BUF_W-1:0] rd_start = {{(spc_pkg::BUF_W - STEP_W){1'b0}}, start_speed_step};
    wire [spc_pkg::BUF_W-1:0] rd_max = {{(spc_pkg::BUF_W - STEP_W){1'b0}}, max_speed_step};
    wire [spc_pkg::BUF_W-1:0] rd_ramp = {{(spc_pkg::BUF_W - RAMP_W){1'b0}}, ramp_rate};
    wire [spc_pkg::BUF_W-1:0] rd_div = {{(spc_pkg::BUF_W - DIV_W){1'b0}}, speed_scale_divisor};
    wire [spc_pkg::BUF_W-1:0] next_read =
        (register_select_code == spc_pkg::SEL_FEED) ? rd_feed :
        (register_select_code == spc_pkg::SEL_START) ? rd_start :
        (register_select_code == spc_pkg::SEL_MAX) ? rd_max :
        (register_select_code == spc_pkg::SEL_RAMP) ? rd_ramp :
        (register_select_code == spc_pkg::SEL_DIV) ? rd_div : '0;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            read_buffer <= '0;
        end else begin
            read_buffer <= next_read;
        end
    end

    ////////////////////////////////////////////////////////////////
    // settings hold until rewritten
    // write-only updates
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            start_speed_step <= spc_pkg::START_RST;
            max_speed_step <= spc_pkg::MAX_RST;
            ramp_rate <= spc_pkg::RAMP_RST;
            speed_scale_divisor <= spc_pkg::DIV_RST;
        end else begin
            if (wr_start) begin
                start_speed_step <= write_buffer[STEP_W-1:0];
            end
            if (wr_max) begin
                max_speed_step <= write_buffer[STEP_W-1:0];
            end
            if (wr_ramp) begin
                ramp_rate <= write_buffer[RAMP_W-1:0];
            end
            if (wr_div) begin
                speed_scale_divisor <= write_buffer[DIV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // feed amount: a host write wins over a pulse in the same cycle
    // full-width write
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            feed_amount_counter <= spc_pkg::FEED_RST;
        end else if (wr_feed) begin
            feed_amount_counter <= write_buffer[FEED_W-1:0];
        end else if (count_en) begin
            feed_amount_counter <= feed_amount_counter - FEED_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////
    // run control
    always_comb begin
        next_state = state;
        unique case (state)
            spc_pkg::SPC_IDLE: begin
                if (go) begin
                    next_state = spc_pkg::SPC_RUN;
                end
            end
            spc_pkg::SPC_RUN: begin
                if (stopping) begin
                    next_state = spc_pkg::SPC_IDLE;
                end else if (decel_stop_cmd && high_speed_mode) begin
                    next_state = spc_pkg::SPC_DECEL;
                end else if (decel_stop_cmd) begin
                    next_state = spc_pkg::SPC_IDLE;
                end
            end
            spc_pkg::SPC_DECEL: begin
                if (stopping) begin
                    next_state = spc_pkg::SPC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= spc_pkg::SPC_IDLE;
            ramp_cnt <= '0;
        end else begin
            state <= next_state;
            ramp_cnt <= (!running || ramp_tick) ? '0 : ramp_cnt + (RAMP_W + 1)'(1);
        end
    end

    ////////////////////////////////////////////////////////////////
    // speed: start at start step, ramp one step per tick
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            current_speed <= '0;
        end else if (go) begin
            current_speed <= start_speed_step;
        end else if (running && high_speed_mode && ramp_tick) begin
            if (state == spc_pkg::SPC_DECEL) begin
                current_speed <= at_start_speed ? current_speed : current_speed - STEP_W'(1);
            end else if (current_speed < max_speed_step) begin
                current_speed <= current_speed + STEP_W'(1);
            end else if (current_speed > max_speed_step) begin
                current_speed <= current_speed - STEP_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // busy and interrupt; a zero-count start never raises busy
    // immediate stop on zero count
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_out <= 1'b0;
        end else begin
            int_out <= int_on_stop_en && (zero_start || (running && next_state == spc_pkg::SPC_IDLE));
        end
    end

    assign busy_output_pin = running;
    assign main_status_busy = running;

    spc_rate_gen #(
        .STEP_W(STEP_W),
        .DIV_W(DIV_W)
    ) u_rate (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(running),
        .speed_step(current_speed),
        .scale_divisor(speed_scale_divisor),
        .step_pulse(step_pulse)
    );

    ////////////////////////////////////////////////////////////////
    a_count_down: assert property (@(posedge sys_clk) disable iff (sys_rst)
        step_pulse && !count_hold_bit && !wr_feed
        |=> feed_amount_counter == $past(feed_amount_counter) - FEED_W'(1))
        else $error("feed amount did not count down on a pulse");
    a_count_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        count_hold_bit && !wr_feed |=> $stable(feed_amount_counter))
        else $error("feed amount changed while held");
    a_read_feed: assert property (@(posedge sys_clk) disable iff (sys_rst)
        register_select_code == spc_pkg::SEL_FEED |=> read_buffer == $past(feed_amount_counter))
        else $error("read buffer does not show the remaining count");
    a_pos_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pos_done |=> !busy_output_pin ##1 !step_pulse)
        else $error("positioning did not stop at zero");
    a_zero_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
        zero_start |=> !main_status_busy ##1 !step_pulse)
        else $error("zero count start produced activity");
    a_zero_int: assert property (@(posedge sys_clk) disable iff (sys_rst)
        zero_start && int_on_stop_en |=> int_out)
        else $error("no interrupt on zero count start");
    a_read_pad: assert property (@(posedge sys_clk) disable iff (sys_rst)
        register_select_code == spc_pkg::SEL_START
        |=> read_buffer[spc_pkg::BUF_W-1:STEP_W] == '0)
        else $error("start step upper bits not zero");
    a_read_pad_div: assert property (@(posedge sys_clk) disable iff (sys_rst)
        register_select_code == spc_pkg::SEL_DIV |=> read_buffer[spc_pkg::BUF_W-1:DIV_W] == '0)
        else $error("divisor upper bits not zero");
    a_settings_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !reg_write |=> $stable(start_speed_step) && $stable(max_speed_step)
            && $stable(ramp_rate) && $stable(speed_scale_divisor))
        else $error("setting changed without a write");
    a_decel_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        decel_end |=> !busy_output_pin)
        else $error("deceleration did not stop at start speed");
    a_int_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !int_on_stop_en |=> !int_out)
        else $error("interrupt raised while disabled");
    a_ramp_start: assert property (@(posedge sys_clk) disable iff (sys_rst)
        go && !wr_start |=> current_speed == $past(start_speed_step))
        else $error("run did not begin at start speed");

endmodule

/* File: bench/spc_host_model.sv */
// host-side model of one axis: register strobes and command pulses
// assumes the axis samples every input on the rising edge of sys_clk
`timescale 1ns/1ns
module spc_host_model (
    input wire logic sys_clk,
    input wire logic [spc_pkg::BUF_W-1:0] read_buffer,
    output logic [spc_pkg::SEL_W-1:0] register_select_code,
    output logic reg_write,
    output logic [spc_pkg::BUF_W-1:0] write_buffer,
    output logic start_cmd,
    output logic stop_cmd,
    output logic decel_stop_cmd
);
    initial begin
        register_select_code = 4'h0;
        reg_write = 1'b0;
        write_buffer = 24'h000000;
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        decel_stop_cmd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // select, write, step floor
    task automatic write_reg(input logic [3:0] sel, input logic [23:0] data);
        @(negedge sys_clk);
        register_select_code = sel;
        reg_write = 1'b1;
        // a zero speed step would give no step pulses while running
        write_buffer = (sel inside {4'h1, 4'h2} && data[12:0] == 13'h0000) ? 24'h000001 : data;
        @(negedge sys_clk);
        reg_write = 1'b0;
        // released data never repeats the last word
        write_buffer = ~write_buffer;
    endtask

    task automatic read_reg(input logic [3:0] sel, output logic [23:0] data);
        @(negedge sys_clk);
        register_select_code = sel;
        @(negedge sys_clk);
        @(negedge sys_clk);
        data = read_buffer;
    endtask

    // which: 0 start, 1 stop, 2 deceleration stop
    task automatic cmd(input int which);
        @(negedge sys_clk);
        start_cmd = (which == 0);
        stop_cmd = (which == 1);
        decel_stop_cmd = (which == 2);
        @(negedge sys_clk);
        start_cmd = 1'b0;
        stop_cmd = 1'b0;
        decel_stop_cmd = 1'b0;
    endtask
endmodule

/* File: bench/stepper_pulse_count_speed_regs_test.sv */
// self-checking bench for one axis driven through the host model
// assumes a 10 MHz sys_clk and the reset values chosen in the package
`timescale 1ns/1ns
module stepper_pulse_count_speed_regs_test;
    logic sys_clk, sys_rst, ext_stop_pin, positioning_mode, high_speed_mode;
    logic s_curve_mode, count_hold_bit, int_on_stop_en;
    logic [3:0] register_select_code;
    logic reg_write, start_cmd, stop_cmd, decel_stop_cmd;
    logic busy_output_pin, main_status_busy, int_out, step_pulse;
    logic [23:0] write_buffer, read_buffer, rd;
    logic [12:0] current_speed;
    logic [23:0] rst_v [6] = '{24'h000000, 24'h000001, 24'h000001, 24'h000001, 24'h000002, 24'h0};
    logic [23:0] max_v [6] = '{24'hffffff, 24'h001fff, 24'h001fff, 24'h00ffff, 24'h0003ff, 24'h0};
    int n_fail = 0, checks_done = 0, n_pulse = 0, n_int = 0, c;

    spc_axis dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .register_select_code(register_select_code), .reg_write(reg_write),
        .write_buffer(write_buffer), .read_buffer(read_buffer), .start_cmd(start_cmd),
        .stop_cmd(stop_cmd), .decel_stop_cmd(decel_stop_cmd), .ext_stop_pin(ext_stop_pin),
        .positioning_mode(positioning_mode), .high_speed_mode(high_speed_mode),
        .s_curve_mode(s_curve_mode), .count_hold_bit(count_hold_bit),
        .int_on_stop_en(int_on_stop_en), .busy_output_pin(busy_output_pin),
        .main_status_busy(main_status_busy), .int_out(int_out), .step_pulse(step_pulse),
        .current_speed(current_speed));
    spc_host_model host (.sys_clk(sys_clk), .read_buffer(read_buffer),
        .register_select_code(register_select_code), .reg_write(reg_write),
        .write_buffer(write_buffer), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
        .decel_stop_cmd(decel_stop_cmd));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        n_pulse <= n_pulse + (step_pulse === 1'b1);
        n_int <= n_int + (int_out === 1'b1);
    end

    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            n_fail++;
        end
    endtask

    task automatic near(input logic [23:0] seen, input int exp, input int tol);
        check((seen + tol >= exp && seen <= exp + tol) ? exp[23:0] : seen, exp[23:0]);
    endtask

    // what: 0 busy equals v, 1 speed equals v, 2 pulse count reaches v
    task automatic wait_for(input int what, input int v, input int bound, output int cyc);
        cyc = 0;
        while (!((what == 0 && busy_output_pin === v[0])
                || (what == 1 && current_speed === v[12:0]) || (what == 2 && n_pulse >= v))) begin
            @(negedge sys_clk);
            cyc++;
            if (cyc > bound) begin
                $display("[FAIL] %0t wait ran out", $time);
                n_fail++;
                test_done();
            end
        end
    endtask

    task automatic run_for(input int cycles);
        host.cmd(0);
        repeat (cycles) @(negedge sys_clk);
        host.cmd(1);
        wait_for(0, 0, 50, c);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        {ext_stop_pin, positioning_mode, high_speed_mode, s_curve_mode} = 4'h0;
        {count_hold_bit, int_on_stop_en} = 2'h0;
        sys_rst = 1'b1;
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            host.read_reg(i[3:0], rd);
            check(rd, rst_v[i]);
            host.write_reg(i[3:0], 24'hffffff);
            host.read_reg(i[3:0], rd);
            check(rd, max_v[i]);
        end
        $display("register map test done");
        host.write_reg(4'h4, 24'h000002);
        host.write_reg(4'h1, 24'h001000);
        host.write_reg(4'h2, 24'h001000);
        host.write_reg(4'h0, 24'd1000);
        n_pulse = 0;
        host.cmd(0);
        repeat (400) @(negedge sys_clk);
        near(n_pulse, 100, 2);
        host.read_reg(4'h0, rd);
        near(rd, 1000 - n_pulse, 1);
        host.cmd(1);
        wait_for(0, 0, 50, c);
        host.read_reg(4'h0, rd);
        check(rd, 24'd1000 - n_pulse);
        $display("rate test done");
        count_hold_bit = 1'b1;
        host.write_reg(4'h0, 24'd50);
        n_pulse = 0;
        run_for(100);
        host.read_reg(4'h0, rd);
        check(rd, 24'd50);
        check(n_pulse > 0, 1'b1);
        count_hold_bit = 1'b0;
        $display("count hold test done");
        positioning_mode = 1'b1;
        int_on_stop_en = 1'b1;
        host.write_reg(4'h0, 24'd5);
        {n_pulse, n_int} = 0;
        host.cmd(0);
        check({busy_output_pin, main_status_busy}, 2'b11);
        wait_for(0, 0, 200, c);
        host.read_reg(4'h0, rd);
        check(rd, 24'd0);
        check(n_pulse, 5);
        check(n_int, 1);
        // zero-count start, stop interrupt enabled then disabled
        for (int e = 1; e >= 0; e--) begin
            int_on_stop_en = e[0];
            n_int = 0;
            host.cmd(0);
            repeat (2) @(negedge sys_clk);
            check({busy_output_pin, main_status_busy}, 2'b00);
            check(n_int, e);
            check(n_pulse, 5);
        end
        $display("positioning test done");
        // interrupted runs resume; unramped deceleration stop acts at once
        host.write_reg(4'h0, 24'd60);
        n_pulse = 0;
        for (int k = 0; k < 2; k++) begin
            host.cmd(0);
            wait_for(2, 20 * (k + 1), 400, c);
            if (k == 0) begin
                ext_stop_pin = 1'b1;
                repeat (3) @(negedge sys_clk);
                ext_stop_pin = 1'b0;
            end else begin
                host.cmd(2);
            end
            wait_for(0, 0, 50, c);
            host.read_reg(4'h0, rd);
            check(rd, 24'd60 - n_pulse);
        end
        host.cmd(0);
        wait_for(0, 0, 400, c);
        check(n_pulse, 60);
        $display("resume test done");
        {positioning_mode, high_speed_mode, count_hold_bit} = 3'b011;
        host.write_reg(4'h3, 24'd4);
        host.write_reg(4'h1, 24'd8181);
        host.write_reg(4'h2, 24'd8191);
        for (int s = 0; s < 2; s++) begin
            s_curve_mode = s[0];
            host.cmd(0);
            check(current_speed, 24'd8181);
            wait_for(1, 8191, 500, c);
            near(c, 40 * (s + 1), 3);
            host.cmd(2);
            wait_for(0, 0, 500, c);
            near(c, 40 * (s + 1), 3);
        end
        host.read_reg(4'h1, rd);
        check(rd, 24'd8181);
        host.read_reg(4'h3, rd);
        check(rd, 24'd4);
        $display("ramp test done");
        test_done();
    end
endmodule
